// ===== tua_timer.sv
// Six-channel capture/compare timer with a shared 16-bit modulo counter,
// AXI4-Lite register access and bidirectional channel pins.
// Assumes one 50 MHz clock; pin inputs are asynchronous and synchronised.
//
// Notes on behaviour
// - Qualifying pin edge copies the 16-bit count into the channel value.
// - Two edge/level bits pick rising, falling or either edge.
// - Capture happens whether the flag is set or clear, overwriting.
// - Captured count lands two bus cycles after the pin edge.
// - Capture sets the flag; interrupt raised only when enabled.
// - Reset leaves channel value registers untouched.
// - Compare match sets, clears or toggles the pin per select bits.
// - Compare match sets the flag and may raise an interrupt.
// - Unbuffered compare value takes effect immediately on write.
// - Buffer bit on channel 0, 2, 4 links the pair; lower set first.
// - Last written set of the pair takes control at each overflow.
// - Linked pair: lower control governs, higher pin released.
// - Toggle-on-overflow toggles the pin one clock after the counter wraps from modulo to zero.
// - Period in counter clocks is modulo plus one.
// - Pulse width in counter clocks equals compare value.
// - All channels share one 16-bit modulo counter.
// - Three-bit select picks one of seven rates or external clock.
// - Buffer link bit has priority over the other mode bit.
// - Without toggle-on-overflow only compare matches change the pin.
`timescale 1ns/1ns
`default_nettype none
module tua_timer
    import tua_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // AXI4-Lite write
    input wire logic [9:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [9:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    // Channel pins and external counter clock
    input wire logic [5:0] CH_PIN_IN,
    output logic [5:0] CH_PIN_OUT,
    output logic [5:0] CH_PIN_OE_N_OUT,
    input wire logic EXT_CLK_IN,
    // Processor interrupt request
    output logic IRQ_OUT
);

    function automatic tua_dec_t reg_dec(input logic [7:0] idx);
        logic [7:0] off;
        logic [7:0] q;
        logic [7:0] r;
        reg_dec = '0;
        off = idx - IDX_CH0;
        q = off / IDX_CH_STEP;
        r = off - q * IDX_CH_STEP;
        reg_dec.hit = 1'b1;
        if (idx == IDX_GSC) begin
            reg_dec.kind = K_GSC;
        end else if (idx == IDX_CNTH) begin
            reg_dec.kind = K_CNTH;
        end else if (idx == IDX_CNTL) begin
            reg_dec.kind = K_CNTL;
        end else if (idx == IDX_MODH) begin
            reg_dec.kind = K_MODH;
        end else if (idx == IDX_MODL) begin
            reg_dec.kind = K_MODL;
        end else if (idx >= IDX_CH0 && idx <= IDX_LAST) begin
            reg_dec.chan = q[2:0];
            reg_dec.kind = (r == 8'h00) ? K_CSC :
                           (r == 8'h01) ? K_CVH : K_CVL;
        end else begin
            reg_dec.hit = 1'b0;
        end
    endfunction : reg_dec

    // Link bit has priority over the other mode bit
    function automatic tua_mode_t chan_mode(input tua_chan_ctrl_t c,
                                            input logic partner_link);
        if (partner_link) begin
            chan_mode = CM_OFF;
        end else if (c.buf_link) begin
            chan_mode = CM_BUF;
        end else if (c.mode_sel_lo) begin
            chan_mode = CM_CMP;
        end else if (c.edge_level_sel_hi || c.edge_level_sel_lo) begin
            chan_mode = CM_CAPT;
        end else begin
            chan_mode = CM_OFF;
        end
    endfunction : chan_mode

    // Registers
    logic [7:0] gsc_ff;
    logic [15:0] mod_ff;
    logic [15:0] cnt_ff;
    logic [6:0] presc_ff;
    logic upd_ff;
    logic ovf_d_ff;
    tua_chan_ctrl_t ctrl_ff [6];
    logic [15:0] val_ff [6];
    logic [5:0] pin_ff;
    logic [2:0] act_hi_ff;
    logic [2:0] last_hi_ff;
    logic [5:0] pin_s1_ff;
    logic [5:0] pin_s2_ff;
    logic [5:0] pin_s3_ff;
    logic [2:0] ext_sync_ff;
    // Bus registers
    logic [7:0] aw_idx_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;

    // Combinational
    tua_mode_t mode [6];
    logic [15:0] cmp_val [6];
    logic [5:0] rise;
    logic [5:0] fall;
    logic [5:0] cap_ev;
    logic [5:0] match;
    logic [6:0] ps_mask;
    logic tick;
    logic ovf;
    logic do_wr;
    logic wr_en;
    tua_dec_t wdec;
    tua_dec_t rdec;
    logic trst;

    assign wdec = reg_dec(aw_idx_ff);
    assign rdec = reg_dec(AXI_ARADDR_IN[9:2]);
    assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_en = do_wr && wstrb0_ff && wdec.hit;
    assign trst = wr_en && wdec.kind == K_GSC && wdata_ff[GSC_TRST_BIT];

    // Prescaler tick or synchronised external clock edge
    assign ps_mask = 7'((8'h01 << gsc_ff[GSC_PS_LSB +: 3]) - 8'h01);
    always_comb begin
        if (gsc_ff[GSC_STOP_BIT]) begin
            tick = 1'b0;
        end else if (gsc_ff[GSC_PS_LSB +: 3] == PS_EXT) begin
            tick = ext_sync_ff[1] && !ext_sync_ff[2];
        end else begin
            tick = (presc_ff & ps_mask) == ps_mask;
        end
    end

    // Overflow in the same cycle as the wrap
    assign ovf = tick && cnt_ff == mod_ff && !trst;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            mode[i] = chan_mode(ctrl_ff[i],
                                i % 2 == 1 && ctrl_ff[i - i % 2].buf_link);
            rise[i] = pin_s2_ff[i] && !pin_s3_ff[i];
            fall[i] = !pin_s2_ff[i] && pin_s3_ff[i];
            cap_ev[i] = mode[i] == CM_CAPT &&
                ((ctrl_ff[i].edge_level_sel_lo && rise[i]) ||
                 (ctrl_ff[i].edge_level_sel_hi && fall[i]));
            cmp_val[i] = val_ff[i];
            if (i % 2 == 0 && mode[i] == CM_BUF && act_hi_ff[i / 2]) begin
                cmp_val[i] = val_ff[i + 1];
            end
            match[i] = upd_ff && cnt_ff == cmp_val[i] &&
                (mode[i] == CM_CMP || mode[i] == CM_BUF);
            CH_PIN_OE_N_OUT[i] = !(mode[i] == CM_CMP ||
                                   mode[i] == CM_BUF);
        end
    end

    // Synchronisers and history
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pin_s1_ff <= 6'h00;
            pin_s2_ff <= 6'h00;
            pin_s3_ff <= 6'h00;
            ext_sync_ff <= 3'h0;
        end else begin
            pin_s1_ff <= CH_PIN_IN;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            ext_sync_ff <= {ext_sync_ff[1:0], EXT_CLK_IN};
        end
    end

    // Shared counter and prescaler
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cnt_ff <= 16'h0000;
            presc_ff <= 7'h00;
            upd_ff <= 1'b0;
            ovf_d_ff <= 1'b0;
        end else if (trst) begin
            cnt_ff <= 16'h0000;
            presc_ff <= 7'h00;
            upd_ff <= 1'b0;
            ovf_d_ff <= 1'b0;
        end else begin
            presc_ff <= gsc_ff[GSC_STOP_BIT] ? presc_ff : presc_ff + 7'h01;
            upd_ff <= tick;
            // Overflow toggle lines up with the compare action
            ovf_d_ff <= ovf;
            if (ovf) begin
                cnt_ff <= 16'h0000;
            end else if (tick) begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    // Global control and overflow flag
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            gsc_ff <= GSC_RST;
            mod_ff <= MOD_RST;
        end else begin
            if (wr_en && wdec.kind == K_GSC) begin
                gsc_ff[6:0] <= {wdata_ff[6:5], 2'h0, wdata_ff[2:0]};
                if (!wdata_ff[GSC_OVF_BIT]) begin
                    gsc_ff[GSC_OVF_BIT] <= 1'b0;
                end
            end
            if (ovf) begin
                gsc_ff[GSC_OVF_BIT] <= 1'b1;
            end
            if (wr_en && wdec.kind == K_MODH) begin
                mod_ff[15:8] <= wdata_ff;
            end
            if (wr_en && wdec.kind == K_MODL) begin
                mod_ff[7:0] <= wdata_ff;
            end
        end
    end

    // Channel control and event flags; set wins over clear
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            for (int i = 0; i < 6; i++) begin
                ctrl_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (wr_en && wdec.kind == K_CSC && wdec.chan == 3'(i)) begin
                    ctrl_ff[i].ie <= wdata_ff[6];
                    ctrl_ff[i].buf_link <= (i % 2 == 0) && wdata_ff[5];
                    ctrl_ff[i][4:0] <= wdata_ff[4:0];
                    if (!wdata_ff[CSC_FLAG_BIT]) begin
                        ctrl_ff[i].flag <= 1'b0;
                    end
                end
                if (cap_ev[i] || match[i]) begin
                    ctrl_ff[i].flag <= 1'b1;
                end
            end
        end
    end

    // Value registers hold across reset
    always_ff @(posedge CLK_IN) begin
        for (int i = 0; i < 6; i++) begin
            if (cap_ev[i]) begin
                val_ff[i] <= cnt_ff;
            end else if (wr_en && wdec.chan == 3'(i)) begin
                if (wdec.kind == K_CVH) begin
                    val_ff[i][15:8] <= wdata_ff;
                end
                if (wdec.kind == K_CVL) begin
                    val_ff[i][7:0] <= wdata_ff;
                end
            end
        end
    end

    // Buffered pair selection
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            act_hi_ff <= 3'h0;
            last_hi_ff <= 3'h0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (mode[2 * p] != CM_BUF) begin
                    act_hi_ff[p] <= 1'b0;
                    last_hi_ff[p] <= 1'b0;
                end else begin
                    if (wr_en && wdec.chan[2:1] == 2'(p) &&
                        (wdec.kind == K_CVH || wdec.kind == K_CVL)) begin
                        last_hi_ff[p] <= wdec.chan[0];
                    end
                    if (ovf) begin
                        act_hi_ff[p] <= last_hi_ff[p];
                    end
                end
            end
        end
    end

    // Pin drive: compare action wins over overflow toggle
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pin_ff <= 6'h00;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (match[i]) begin
                    case ({ctrl_ff[i].edge_level_sel_hi,
                           ctrl_ff[i].edge_level_sel_lo})
                        2'h1: pin_ff[i] <= !pin_ff[i];
                        2'h2: pin_ff[i] <= 1'b0;
                        2'h3: pin_ff[i] <= 1'b1;
                        default: pin_ff[i] <= pin_ff[i];
                    endcase
                end else if (ovf_d_ff && ctrl_ff[i].toggle_at_overflow &&
                             (mode[i] == CM_CMP || mode[i] == CM_BUF)) begin
                    pin_ff[i] <= !pin_ff[i];
                end
            end
        end
    end
    assign CH_PIN_OUT = pin_ff;

    always_comb begin
        IRQ_OUT = gsc_ff[GSC_OVF_BIT] && gsc_ff[GSC_OVIE_BIT];
        for (int i = 0; i < 6; i++) begin
            IRQ_OUT = IRQ_OUT || (ctrl_ff[i].flag && ctrl_ff[i].ie);
        end
    end

    // AXI4-Lite write channel
    assign AXI_AWREADY_OUT = !aw_got_ff && !bvalid_ff;
    assign AXI_WREADY_OUT = !w_got_ff && !bvalid_ff;
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            aw_idx_ff <= 8'h00;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
                aw_idx_ff <= AXI_AWADDR_IN[9:2];
                aw_got_ff <= 1'b1;
            end
            if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
                wdata_ff <= AXI_WDATA_IN[7:0];
                wstrb0_ff <= AXI_WSTRB_IN[0];
                w_got_ff <= 1'b1;
            end
            if (do_wr) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wdec.hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && AXI_BREADY_IN) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign AXI_BVALID_OUT = bvalid_ff;
    assign AXI_BRESP_OUT = bresp_ff;

    // AXI4-Lite read channel
    assign AXI_ARREADY_OUT = !rvalid_ff;
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rdec.hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= 32'h00000000;
            if (rdec.hit) begin
                case (rdec.kind)
                    K_GSC: rdata_ff[7:0] <= gsc_ff;
                    K_CNTH: rdata_ff[7:0] <= cnt_ff[15:8];
                    K_CNTL: rdata_ff[7:0] <= cnt_ff[7:0];
                    K_MODH: rdata_ff[7:0] <= mod_ff[15:8];
                    K_MODL: rdata_ff[7:0] <= mod_ff[7:0];
                    K_CSC: rdata_ff[7:0] <= ctrl_ff[rdec.chan];
                    K_CVH: rdata_ff[7:0] <= val_ff[rdec.chan][15:8];
                    K_CVL: rdata_ff[7:0] <= val_ff[rdec.chan][7:0];
                    default: rdata_ff[7:0] <= 8'h00;
                endcase
            end
        end else if (rvalid_ff && AXI_RREADY_IN) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign AXI_RVALID_OUT = rvalid_ff;
    assign AXI_RRESP_OUT = rresp_ff;
    assign AXI_RDATA_OUT = rdata_ff;

    // Checks
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    cap_value_a: assert property (cap_ev[0] |=>
        val_ff[0] == $past(cnt_ff)) else $error("capture value wrong");
    cap_edge_a: assert property ((mode[0] == CM_CAPT &&
        !ctrl_ff[0].edge_level_sel_lo && rise[0]) |-> !cap_ev[0])
        else $error("capture on unselected edge");
    cap_flagset_a: assert property ((cap_ev[0] &&
        ctrl_ff[0].flag) |=> val_ff[0] == $past(cnt_ff))
        else $error("capture skipped while flag set");
    cap_delay_a: assert property (cap_ev[0] |->
        $past(CH_PIN_IN[0], 2) != $past(CH_PIN_IN[0], 3))
        else $error("capture not two cycles after edge");
    cap_irq_a: assert property ((cap_ev[0] && ctrl_ff[0].ie)
        |=> IRQ_OUT && ctrl_ff[0].flag) else $error("capture irq missing");
    cmp_clear_a: assert property ((match[2] &&
        ctrl_ff[2].edge_level_sel_hi && !ctrl_ff[2].edge_level_sel_lo)
        |=> !CH_PIN_OUT[2]) else $error("clear on compare failed");
    cmp_irq_a: assert property ((match[2] && ctrl_ff[2].ie)
        |=> ##[0:1] IRQ_OUT) else $error("compare irq missing");
    pair_release_a: assert property (ctrl_ff[4].buf_link
        |-> CH_PIN_OE_N_OUT[5]) else $error("linked pin still driven");
    buf_swap_a: assert property ((mode[4] == CM_BUF && ovf &&
        last_hi_ff[2]) |=> act_hi_ff[2]) else $error("buffer swap missed");
    tov_toggle_a: assert property ((ovf_d_ff && !match[2] &&
        mode[2] == CM_CMP && ctrl_ff[2].toggle_at_overflow)
        |=> CH_PIN_OUT[2] != $past(CH_PIN_OUT[2]))
        else $error("overflow toggle missed");
    no_tov_a: assert property ((ovf_d_ff && !match[2] &&
        !ctrl_ff[2].toggle_at_overflow) |=> $stable(CH_PIN_OUT[2]))
        else $error("pin toggled without toggle enable");
    cnt_wrap_a: assert property (ovf && !trst |=>
        cnt_ff == 16'h0000 && gsc_ff[GSC_OVF_BIT])
        else $error("counter did not wrap");

endmodule : tua_timer
`default_nettype wire

// ===== tua_pkg.sv
// Package for the six-channel capture/compare timer: register indices,
// field positions, reset values, modes and carrier types.
// Assumes an AXI4-Lite host with 32-bit data, one register per word.
package tua_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_GSC = 8'h20;
    localparam logic [7:0] IDX_CNTH = 8'h22;
    localparam logic [7:0] IDX_CNTL = 8'h23;
    localparam logic [7:0] IDX_MODH = 8'h24;
    localparam logic [7:0] IDX_MODL = 8'h25;
    localparam logic [7:0] IDX_CH0 = 8'h26;
    localparam logic [7:0] IDX_CH_STEP = 8'h03;
    localparam logic [7:0] IDX_LAST = 8'h37;

    // Global status/control field positions and the channel flag bit
    localparam int GSC_OVF_BIT = 7;
    localparam int GSC_OVIE_BIT = 6;
    localparam int GSC_STOP_BIT = 5;
    localparam int GSC_TRST_BIT = 4;
    localparam int GSC_PS_LSB = 0;
    localparam int CSC_FLAG_BIT = 7;

    // Reset values and the external clock select code
    localparam logic [7:0] GSC_RST = 8'h20;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [2:0] PS_EXT = 3'h7;

    // Timing
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int CAPT_DELAY_BUS_CYC = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded register kinds
    localparam logic [2:0] K_GSC = 3'h0;
    localparam logic [2:0] K_CNTH = 3'h1;
    localparam logic [2:0] K_CNTL = 3'h2;
    localparam logic [2:0] K_MODH = 3'h3;
    localparam logic [2:0] K_MODL = 3'h4;
    localparam logic [2:0] K_CSC = 3'h5;
    localparam logic [2:0] K_CVH = 3'h6;
    localparam logic [2:0] K_CVL = 3'h7;

    typedef enum logic [3:0] {
        CM_OFF = 4'h1,
        CM_CAPT = 4'h2,
        CM_CMP = 4'h4,
        CM_BUF = 4'h8
    } tua_mode_t;

    // Channel status/control carrier
    typedef struct packed {
        logic flag;
        logic ie;
        logic buf_link;
        logic mode_sel_lo;
        logic edge_level_sel_hi;
        logic edge_level_sel_lo;
        logic toggle_at_overflow;
        logic max_bit;
    } tua_chan_ctrl_t;

    typedef struct packed {
        logic hit;
        logic [2:0] kind;
        logic [2:0] chan;
    } tua_dec_t;

endpackage : tua_pkg

// ===== tua_pin_model.sv
// Model of the outside world on the six channel pins.
// Assumes the bench sets the level that the far side drives.
`timescale 1ns/1ns
`default_nettype none
module tua_pin_model (
    // Device side
    input wire logic [5:0] pin_out_in,
    input wire logic [5:0] oe_n_in,
    // Far side drive levels
    input wire logic [5:0] drive_in,
    // Resolved wire levels
    output logic [5:0] wire_out
);
    // Device wins where it drives; far side drives released pins
    assign wire_out = (~oe_n_in & pin_out_in) | (oe_n_in & drive_in);
endmodule : tua_pin_model
`default_nettype wire

// ===== tb_top.sv
// Testbench for the capture/compare timer over AXI4-Lite.
// Assumes the pin model closes the loop on the channel pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tua_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [5:0] drv = 6'h00;
    logic ext = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd, h, l;
    logic [5:0] pin_out, oe_n, pin_lvl;
    logic [15:0] cap;
    logic fl;
    int errors = 0, tests_run = 0, hi2, hi4, r2, s, e;

    always #10 clk = ~clk;

    tua_timer dut (
        .CLK_IN(clk), .NRST_IN(nrst),
        .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
        .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata),
        .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid),
        .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
        .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
        .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
        .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
        .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
        .AXI_RREADY_IN(rready), .CH_PIN_IN(pin_lvl),
        .CH_PIN_OUT(pin_out), .CH_PIN_OE_N_OUT(oe_n),
        .EXT_CLK_IN(ext), .IRQ_OUT(irq)
    );

    tua_pin_model partner (
        .pin_out_in(pin_out), .oe_n_in(oe_n),
        .drive_in(drv), .wire_out(pin_lvl)
    );

    task complete_run;
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk

    task bound(input int n);
        if (n >= 40) begin
            errors++;
            complete_run();
        end
    endtask : bound

    task axw(input logic [7:0] idx, input logic [7:0] d);
        logic ta, tw, b;
        int n;
        b = 1'b0;
        n = 0;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b && n < 40) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            b = bvalid;
            resp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        bound(n);
    endtask : axw

    task axr(input logic [7:0] idx, output logic [31:0] d);
        logic ta, v;
        int n;
        v = 1'b0;
        n = 0;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!v && n < 40) begin
            @(negedge clk);
            ta = arvalid && arready;
            v = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        bound(n);
    endtask : axr

    // Poll a register until one bit reads set
    task wait_set(input logic [7:0] idx, input int b);
        int n;
        n = 0;
        rd = 32'h00000000;
        while (!rd[b] && n < 40) begin
            axr(idx, rd);
            n++;
        end
        bound(n);
    endtask : wait_set

    // High time of pins 2 and 4 and rises of pin 2 over 64 cycles
    task measure;
        logic p;
        repeat (16) @(posedge clk);
        hi2 = 0;
        hi4 = 0;
        r2 = 0;
        @(negedge clk);
        p = pin_out[2];
        repeat (64) begin
            @(negedge clk);
            hi2 += pin_out[2];
            hi4 += pin_out[4];
            r2 += (pin_out[2] && !p);
            p = pin_out[2];
        end
    endtask : measure

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        axr(IDX_GSC, rd);
        chk(rd, {24'h000000, GSC_RST});
        axr(IDX_MODL, rd);
        chk(rd, 32'h000000FF);
        axr(8'h38, rd);
        chk(resp, RESP_SLVERR);
        axw(8'h38, 8'h55);
        chk(resp, RESP_SLVERR);
        // Each edge select against rising then falling pin edges
        for (s = 1; s < 4; s++) begin
            axw(8'h26, 8'h40 | 8'(s << 2));
            fl = 1'b0;
            for (e = 0; e < 2; e++) begin
                axw(IDX_GSC, 8'h00);
                axw(IDX_GSC, 8'h20);
                axr(IDX_CNTH, h);
                axr(IDX_CNTL, l);
                drv[0] <= (e == 0);
                repeat (6) @(posedge clk);
                if (s[e]) begin
                    fl = 1'b1;
                    cap = {h[7:0], l[7:0]};
                end
                axr(8'h27, rd);
                chk(rd, {24'h000000, cap[15:8]});
                axr(8'h28, rd);
                chk(rd, {24'h000000, cap[7:0]});
                chk(irq, fl);
            end
        end
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        axr(8'h27, rd);
        chk(rd, {24'h000000, cap[15:8]});
        axr(8'h28, rd);
        chk(rd, {24'h000000, cap[7:0]});
        // External counter clock: five rising edges, five counts
        axw(IDX_GSC, 8'h17);
        repeat (5) begin
            ext <= 1'b1;
            repeat (3) @(posedge clk);
            ext <= 1'b0;
            repeat (3) @(posedge clk);
        end
        axr(IDX_CNTL, rd);
        chk(rd, 32'h00000005);
        // PWM: period 8, channel 2 plain, pair 4/5 buffered
        axw(IDX_MODH, 8'h00);
        axw(IDX_MODL, 8'h07);
        axw(8'h2D, 8'h00);
        axw(8'h2E, 8'h03);
        axw(8'h2C, 8'h5A);
        axw(8'h33, 8'h00);
        axw(8'h34, 8'h02);
        axw(8'h32, 8'h3A);
        axw(8'h36, 8'h00);
        axw(8'h37, 8'h05);
        axw(IDX_GSC, 8'h10);
        measure();
        chk(hi2, 3 * 8);
        chk(r2, 8);
        chk(hi4, 5 * 8);
        chk(oe_n, 6'h2B);
        axw(8'h34, 8'h01);
        axw(IDX_GSC, 8'h00);
        wait_set(IDX_GSC, GSC_OVF_BIT);
        axw(8'h2E, 8'h06);
        measure();
        chk(hi4, 1 * 8);
        chk(hi2, 6 * 8);
        // Shorter pulse written from the compare event
        axw(8'h2C, 8'h5A);
        wait_set(8'h2C, CSC_FLAG_BIT);
        axw(8'h2E, 8'h02);
        repeat (8) @(posedge clk);
        measure();
        chk(hi2, 2 * 8);
        axw(8'h2C, 8'h18);
        measure();
        chk(r2, 0);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
